// ---- rtl/srap_host.v ----
// host controller driving the spi or two-wire register port of a touch controller
`timescale 1ns/10ps
`include "srap_defines.vh"
// Notes on behaviour
// - spi write sends command word with direction 0, then 16-bit data words
// - single spi write always shifts a full 32 bits
// - device samples input on rising clock; clock may idle low or high
// - command word is 11100, direction bit, then ten address bits
// - spi read sends command with direction 1, then 16 clocks per word
// - host keeps chip select low until every read bit is clocked
// - direction bit after slave address: 0 write, 1 read
// - two address bytes follow: bits 9:8 low in first, 7:0 second
// - third byte is data high, fourth data low, paired per register
// - host sends an even number of data bytes unless a high data byte is not acknowledged
// - host ends two-wire write with a stop, never a repeated start
// - spi transfer starts with chip select falling; output on falling edges
// - two-wire read sets pointer by write, restarts, high byte first
module srap_host (
  // clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // user request
  input  wire        start_req,
  input  wire        use_i2c,
  input  wire        rnw,
  input  wire [9:0]  reg_addr,
  input  wire [7:0]  word_cnt,
  input  wire [15:0] wr_data,
  input  wire        slave_addr_strap_high,
  input  wire        slave_addr_strap_low,
  // user answer
  output reg         busy,
  output reg         wr_take,
  output reg         rd_valid,
  output reg  [15:0] rd_data,
  output reg         nack_err,
  // spi pins
  output reg         spi_cs_n,
  output reg         spi_sclk,
  output reg         serial_in_pin,
  input  wire        serial_out_pin,
  // two-wire pins
  output reg         i2c_scl,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        sda_in
);

  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_SHIFT = 5'h04;
  localparam [4:0] S_ACK   = 5'h08;
  localparam [4:0] S_STOP  = 5'h10;

  localparam integer QTR_LAST_I = `SRAP_QTR_CYC - 1;
  localparam [3:0]   QTR_LAST   = QTR_LAST_I[3:0];

  reg  [4:0]  state_ff;
  reg  [3:0]  div_ff;
  reg  [1:0]  ph_ff;
  reg  [3:0]  bit_ff;
  reg  [15:0] sh_ff;
  reg  [15:0] rx_ff;
  reg  [7:0]  lo_ff;
  reg  [2:0]  step_ff;
  reg  [7:0]  words_ff;
  reg         i2c_ff;
  reg         rnw_ff;
  reg         in_cmd_ff;
  reg  [9:0]  addr_ff;
  reg  [1:0]  strap_ff;
  wire [1:0]  pins_s;
  wire        miso_s;
  wire        sda_s;
  wire        tick;
  wire        last_word;
  wire        rx_step;

  srap_sync u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({serial_out_pin, sda_in}),
    .sync_out (pins_s)
  );

  assign miso_s    = pins_s[1];
  assign sda_s     = pins_s[0];
  assign tick      = (div_ff == QTR_LAST);
  assign last_word = (words_ff == 8'h01);
  assign rx_step   = (step_ff == `SRAP_STEP_RHI) || (step_ff == `SRAP_STEP_RLO);

  // command word: enable pattern, direction, start address
  function [15:0] spi_cmd;
    input       dir;
    input [9:0] addr;
    begin
      spi_cmd = {`SRAP_CMD_EN_PAT, dir, addr};
    end
  endfunction

  // slave address byte in the upper half of the shifter
  function [15:0] dev_byte;
    input       dir;
    input [1:0] strap;
    begin
      dev_byte = {`SRAP_DEV_HI_PAT, strap, dir, 8'h00};
    end
  endfunction

  always @(posedge mclk) begin
    if (!reset_n) begin
      state_ff      <= S_IDLE;
      div_ff        <= 4'h0;
      ph_ff         <= 2'h0;
      bit_ff        <= 4'h0;
      sh_ff         <= `SRAP_RST_WORD;
      rx_ff         <= `SRAP_RST_WORD;
      lo_ff         <= 8'h00;
      step_ff       <= `SRAP_STEP_DEVW;
      words_ff      <= 8'h00;
      i2c_ff        <= 1'b0;
      rnw_ff        <= 1'b0;
      in_cmd_ff     <= 1'b0;
      addr_ff       <= 10'h000;
      strap_ff      <= 2'h0;
      busy          <= 1'b0;
      wr_take       <= 1'b0;
      rd_valid      <= 1'b0;
      rd_data       <= `SRAP_RST_WORD;
      nack_err      <= 1'b0;
      spi_cs_n      <= 1'b1;
      spi_sclk      <= 1'b0;
      serial_in_pin <= 1'b0;
      i2c_scl       <= 1'b1;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
    end else begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      sda_out  <= 1'b0;
      if (state_ff == S_IDLE) begin
        div_ff <= 4'h0;
        ph_ff  <= 2'h0;
        if (start_req) begin
          state_ff  <= S_START;
          busy      <= 1'b1;
          nack_err  <= 1'b0;
          i2c_ff    <= use_i2c;
          rnw_ff    <= rnw;
          addr_ff   <= reg_addr;
          words_ff  <= word_cnt;
          strap_ff  <= {slave_addr_strap_high, slave_addr_strap_low};
          step_ff   <= `SRAP_STEP_DEVW;
          in_cmd_ff <= 1'b1;
          if (use_i2c) begin
            sh_ff <= dev_byte(1'b0, {slave_addr_strap_high, slave_addr_strap_low});
          end else begin
            sh_ff    <= spi_cmd(rnw, reg_addr);
            spi_cs_n <= 1'b0;
          end
        end
      end else begin
        div_ff <= tick ? 4'h0 : div_ff + 4'h1;
        if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          case (state_ff)
            S_START: begin
              // start or repeated start: high-to-low on data while clock high
              if (i2c_ff) begin
                case (ph_ff)
                  2'h0: begin
                    i2c_scl <= 1'b0;
                    sda_oe  <= 1'b0;
                  end
                  2'h1: i2c_scl <= 1'b1;
                  2'h2: sda_oe <= 1'b1;
                  default: begin
                    state_ff <= S_SHIFT;
                    bit_ff   <= `SRAP_I2C_BITS;
                  end
                endcase
              end else if (ph_ff == 2'h3) begin
                state_ff <= S_SHIFT;
                bit_ff   <= `SRAP_SPI_BITS;
              end
            end
            S_SHIFT: begin
              case (ph_ff)
                2'h0: begin
                  // data changes only while the clock is low
                  if (i2c_ff) begin
                    i2c_scl <= 1'b0;
                    sda_oe  <= rx_step ? 1'b0 : ~sh_ff[15];
                  end else begin
                    spi_sclk      <= 1'b0;
                    serial_in_pin <= sh_ff[15];
                  end
                end
                2'h2: begin
                  if (i2c_ff) begin
                    i2c_scl <= 1'b1;
                  end else begin
                    spi_sclk <= 1'b1;
                  end
                end
                2'h3: begin
                  // sample late in the high phase to cover the synchroniser lag
                  rx_ff  <= {rx_ff[14:0], i2c_ff ? sda_s : miso_s};
                  sh_ff  <= {sh_ff[14:0], 1'b0};
                  bit_ff <= bit_ff - 4'h1;
                  if (bit_ff == 4'h0) begin
                    if (i2c_ff) begin
                      state_ff <= S_ACK;
                    end else if (in_cmd_ff) begin
                      in_cmd_ff <= 1'b0;
                      bit_ff    <= `SRAP_SPI_BITS;
                      if (!rnw_ff) begin
                        sh_ff   <= wr_data;
                        wr_take <= 1'b1;
                      end
                    end else begin
                      words_ff <= words_ff - 8'h01;
                      bit_ff   <= `SRAP_SPI_BITS;
                      if (rnw_ff) begin
                        rd_data  <= {rx_ff[14:0], miso_s};
                        rd_valid <= 1'b1;
                      end
                      if (last_word) begin
                        state_ff <= S_STOP;
                      end else if (!rnw_ff) begin
                        sh_ff   <= wr_data;
                        wr_take <= 1'b1;
                      end
                    end
                  end
                end
                default: begin
                end
              endcase
            end
            S_ACK: begin
              case (ph_ff)
                2'h0: begin
                  i2c_scl <= 1'b0;
                  // host acknowledges read bytes except the very last one
                  sda_oe  <= rx_step && !(step_ff == `SRAP_STEP_RLO && last_word);
                end
                2'h2: i2c_scl <= 1'b1;
                2'h3: begin
                  bit_ff   <= `SRAP_I2C_BITS;
                  state_ff <= S_SHIFT;
                  if (!rx_step && sda_s) begin
                    nack_err <= 1'b1;
                    state_ff <= S_STOP;
                  end else begin
                    case (step_ff)
                      `SRAP_STEP_DEVW: begin
                        step_ff <= `SRAP_STEP_AHI;
                        sh_ff   <= {6'h00, addr_ff[9:8], 8'h00};
                      end
                      `SRAP_STEP_AHI: begin
                        step_ff <= `SRAP_STEP_ALO;
                        sh_ff   <= {addr_ff[7:0], 8'h00};
                      end
                      `SRAP_STEP_ALO: begin
                        if (rnw_ff) begin
                          step_ff  <= `SRAP_STEP_DEVR;
                          sh_ff    <= dev_byte(1'b1, strap_ff);
                          state_ff <= S_START;
                        end else begin
                          step_ff <= `SRAP_STEP_DHI;
                          sh_ff   <= {wr_data[15:8], 8'h00};
                          lo_ff   <= wr_data[7:0];
                          wr_take <= 1'b1;
                        end
                      end
                      `SRAP_STEP_DHI: begin
                        step_ff <= `SRAP_STEP_DLO;
                        sh_ff   <= {lo_ff, 8'h00};
                      end
                      `SRAP_STEP_DLO: begin
                        words_ff <= words_ff - 8'h01;
                        if (last_word) begin
                          state_ff <= S_STOP;
                        end else begin
                          step_ff <= `SRAP_STEP_DHI;
                          sh_ff   <= {wr_data[15:8], 8'h00};
                          lo_ff   <= wr_data[7:0];
                          wr_take <= 1'b1;
                        end
                      end
                      `SRAP_STEP_DEVR: step_ff <= `SRAP_STEP_RHI;
                      `SRAP_STEP_RHI:  step_ff <= `SRAP_STEP_RLO;
                      default: begin
                        // pair of read bytes completes, high byte first
                        rd_data  <= rx_ff;
                        rd_valid <= 1'b1;
                        words_ff <= words_ff - 8'h01;
                        step_ff  <= `SRAP_STEP_RHI;
                        if (last_word) begin
                          state_ff <= S_STOP;
                        end
                      end
                    endcase
                  end
                end
                default: begin
                end
              endcase
            end
            S_STOP: begin
              case (ph_ff)
                2'h0: begin
                  if (i2c_ff) begin
                    i2c_scl <= 1'b0;
                    sda_oe  <= 1'b1;
                  end else begin
                    spi_sclk <= 1'b0;
                  end
                end
                2'h1: i2c_scl <= 1'b1;
                2'h2: begin
                  // low-to-high on data while clock high resets the device pointer
                  sda_oe   <= 1'b0;
                  spi_cs_n <= 1'b1;
                end
                default: begin
                  state_ff <= S_IDLE;
                  busy     <= 1'b0;
                end
              endcase
            end
            default: state_ff <= S_IDLE;
          endcase
        end
      end
    end
  end

endmodule

// ---- include/srap_defines.vh ----
// timing, field and step constants for the serial register access host
`ifndef SRAP_DEFINES_VH
`define SRAP_DEFINES_VH

// clock and link timing: one link bit is four quarter phases
`define SRAP_CLK_MHZ      10
`define SRAP_QTR_NS       200
`define SRAP_QTR_CYC      ((`SRAP_QTR_NS * `SRAP_CLK_MHZ) / 1000)

// spi command word layout
`define SRAP_CMD_EN_PAT   5'h1c
`define SRAP_CMD_EN_MSB   15
`define SRAP_CMD_EN_LSB   11
`define SRAP_CMD_RNW_BIT  10
`define SRAP_SPI_BITS     4'hf

// two-wire addressing
`define SRAP_DEV_HI_PAT   5'h0b
`define SRAP_I2C_BITS     4'h7

// two-wire byte steps
`define SRAP_STEP_DEVW    3'h0
`define SRAP_STEP_AHI     3'h1
`define SRAP_STEP_ALO     3'h2
`define SRAP_STEP_DHI     3'h3
`define SRAP_STEP_DLO     3'h4
`define SRAP_STEP_DEVR    3'h5
`define SRAP_STEP_RHI     3'h6
`define SRAP_STEP_RLO     3'h7

// reset values
`define SRAP_RST_WORD     16'h0000

`endif

// ---- rtl/srap_sync.v ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module srap_sync (
  // clock and reset
  input  wire       mclk,
  input  wire       reset_n,
  // asynchronous inputs and their filtered copies
  input  wire [1:0] async_in,
  output reg  [1:0] sync_out
);

  reg [1:0] s1_ff;
  reg [1:0] s2_ff;
  reg [1:0] s3_ff;

  // only s2 reads s1; the output moves once stages two and three agree
  always @(posedge mclk) begin
    if (!reset_n) begin
      s1_ff    <= 2'h3;
      s2_ff    <= 2'h3;
      s3_ff    <= 2'h3;
      sync_out <= 2'h3;
    end else begin
      s1_ff    <= async_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      sync_out <= (s2_ff & s3_ff) | (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & sync_out);
    end
  end

endmodule

// ---- dv/srap_checker.sv ----
// concurrent checks on the serial register access host pins
`timescale 1ns/10ps
module srap_checker (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // user side
  input wire use_i2c,
  input wire busy,
  input wire rd_valid,
  // link pins
  input wire spi_cs_n,
  input wire spi_sclk,
  input wire serial_in_pin,
  input wire i2c_scl,
  input wire sda_out,
  input wire sda_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_cs_idle: assert property (!busy |-> spi_cs_n) else $error("select low while idle");
  a_sclk_idle: assert property (spi_cs_n |-> !spi_sclk) else $error("sclk runs unselected");
  a_start_gap: assert property ($fell(spi_cs_n) |-> !spi_sclk [*8]) else $error("short start");
  a_si_steady: assert property (spi_sclk |-> $stable(serial_in_pin)) else $error("si moved");
  a_sclk_high: assert property ($rose(spi_sclk) |-> spi_sclk [*4] ##1 !spi_sclk)
    else $error("sclk high time");
  a_rd_cs_low: assert property (rd_valid && !use_i2c |-> !spi_cs_n) else $error("cs early");
  a_bus_free: assert property (!busy |-> i2c_scl && !sda_oe) else $error("bus held idle");
  a_od_low: assert property (sda_out == 1'h0) else $error("sda driven high");
endmodule

bind srap_host srap_checker u_chk (.mclk(mclk), .reset_n(reset_n), .use_i2c(use_i2c),
  .busy(busy), .rd_valid(rd_valid), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
  .serial_in_pin(serial_in_pin), .i2c_scl(i2c_scl), .sda_out(sda_out), .sda_oe(sda_oe));

// ---- dv/srap_dev_model.sv ----
// behavioural touch controller register port, spi and two-wire slave
`timescale 1ns/10ps
module srap_dev_model #(
  parameter [9:0] TOP = 10'h3ff
) (
  // spi side
  input  wire sclk,
  input  wire cs_n,
  input  wire si,
  output wire so,
  // two-wire side
  input  wire scl,
  input  wire sda,
  output reg  sda_pull,
  // address straps
  input  wire strap_hi,
  input  wire strap_lo
);
  reg [15:0] mem [0:1023];
  reg [15:0] ssh, scmd;
  reg [4:0]  sbc, sbi;
  reg [9:0]  sptr, iptr;
  reg        sdrv, sbit, sfull, ifull, act, half;
  reg [7:0]  sh, dhi;
  reg [3:0]  bc;
  reg [2:0]  st;
  reg [1:0]  ihi;
  wire [7:0] rbyte = half ? mem[iptr][7:0] : mem[iptr][15:8];
  wire       en_ok = (scmd[15:11] == 5'h1c);

  initial begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 16'h0000;
    {sdrv, sbit, act, sda_pull} = 4'h0;
  end

  always @(negedge cs_n) begin
    sbc = 5'h00;
    sfull = 1'h0;
  end
  always @(posedge cs_n) sdrv = 1'h0;
  always @(posedge sclk) if (!cs_n) begin
    ssh = {ssh[14:0], si};
    if (sbc < 5'h10) begin
      sbc = sbc + 5'h01;
      if (sbc == 5'h10) begin
        scmd = ssh;
        sptr = ssh[9:0];
        sbi = 5'h00;
      end
    end else if (en_ok) begin
      sbi = sbi + 5'h01;
      if (sbi == 5'h10) begin
        sbi = 5'h00;
        if (!scmd[10] && !sfull) mem[sptr] = ssh;
        if (sptr == TOP) sfull = 1'h1;
        else sptr = sptr + 10'h001;
      end
    end
  end
  always @(negedge sclk) if (!cs_n && sbc == 5'h10 && en_ok && scmd[10]) begin
    sdrv = 1'h1;
    sbit = mem[sptr][15 - sbi];
  end
  // a released line shows the inverse of its last bit, so stale data never passes
  assign so = sdrv ? sbit : ~sbit;

  // scl is looked at 1 ns late so a clock fall in the same step never fakes a stop
  always @(negedge sda) #1 if (scl === 1'h1) begin
    act = 1'h1;
    bc = 4'h0;
    st = 3'h0;
  end
  always @(posedge sda) #1 if (scl === 1'h1) begin
    act = 1'h0;
    st = 3'h0;
    iptr = 10'h000;
    ifull = 1'h0;
    sda_pull = 1'h0;
  end
  always @(posedge scl) if (act) begin
    if (bc < 4'h8) begin
      sh = {sh[6:0], sda};
      bc = bc + 4'h1;
    end else begin
      bc = 4'h0;
      if (st == 3'h6) begin
        st = 3'h5;
        half = 1'h0;
      end else if (st == 3'h5) begin
        if (sda) act = 1'h0;
        else begin
          if (half && iptr != TOP) iptr = iptr + 10'h001;
          half = ~half;
        end
      end
    end
  end
  always @(negedge scl) if (act) begin
    sda_pull = 1'h0;
    if (st == 3'h5 && bc < 4'h8) sda_pull = ~rbyte[7 - bc];
    else if (bc == 4'h8) case (st)
      3'h0: if (sh[7:1] == {5'h0b, strap_hi, strap_lo}) begin
        sda_pull = 1'h1;
        st = sh[0] ? 3'h6 : 3'h1;
      end else act = 1'h0;
      3'h1: begin
        ihi = sh[1:0];
        sda_pull = 1'h1;
        st = 3'h2;
      end
      3'h2: begin
        iptr = {ihi, sh};
        ifull = 1'h0;
        sda_pull = 1'h1;
        st = 3'h3;
      end
      3'h3: begin
        dhi = sh;
        sda_pull = 1'h1;
        st = 3'h4;
      end
      3'h4: begin
        if (!ifull) mem[iptr] = {dhi, sh};
        if (iptr == TOP) ifull = 1'h1;
        else iptr = iptr + 10'h001;
        sda_pull = 1'h1;
        st = 3'h3;
      end
    endcase
  end
endmodule

// ---- dv/srap_host_tb.sv ----
// self-checking testbench for the serial register access host
`timescale 1ns/10ps
module srap_host_tb;
  localparam logic [9:0] TOP = 10'h020;
  logic        mclk = 1'h0;
  logic        reset_n = 1'h0;
  logic        start_req = 1'h0;
  logic        use_i2c = 1'h0;
  logic        rnw = 1'h0;
  logic [9:0]  reg_addr = 10'h000;
  logic [7:0]  word_cnt = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0]  strap = 2'h0;
  logic [1:0]  dev_strap = 2'h0;
  logic [15:0] wq [0:7];
  logic [15:0] rq [0:7];
  wire         busy, wr_take, rd_valid, nack_err, spi_cs_n, spi_sclk, serial_in_pin;
  wire         serial_out_pin, i2c_scl, sda_out, sda_oe, dev_pull;
  wire [15:0]  rd_data;
  // pulled-up wire: low while either side pulls
  wire         sda_w = ~(sda_oe | dev_pull);
  int          nrd = 0;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #50 mclk = ~mclk;

  srap_host DUT (.mclk(mclk), .reset_n(reset_n), .start_req(start_req), .use_i2c(use_i2c),
    .rnw(rnw), .reg_addr(reg_addr), .word_cnt(word_cnt), .wr_data(wr_data),
    .slave_addr_strap_high(strap[1]), .slave_addr_strap_low(strap[0]), .busy(busy),
    .wr_take(wr_take), .rd_valid(rd_valid), .rd_data(rd_data), .nack_err(nack_err),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .i2c_scl(i2c_scl), .sda_out(sda_out),
    .sda_oe(sda_oe), .sda_in(sda_w));
  srap_dev_model #(.TOP(TOP)) dev (.sclk(spi_sclk), .cs_n(spi_cs_n), .si(serial_in_pin),
    .so(serial_out_pin), .scl(i2c_scl), .sda(sda_w), .sda_pull(dev_pull),
    .strap_hi(dev_strap[1]), .strap_lo(dev_strap[0]));

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        n_fail++;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  // one transaction: next word offered after each take, read words collected
  task run(input logic i2c, input logic r, input logic [9:0] a, input logic [7:0] n);
    int k;
    begin
      k = 0;
      nrd = 0;
      use_i2c = i2c;
      rnw = r;
      reg_addr = a;
      word_cnt = n;
      wr_data = wq[0];
      start_req = 1'h1;
      @(posedge mclk);
      #1 start_req = 1'h0;
      chk({15'h0000, busy}, 16'h0001);
      while (busy === 1'h1) begin
        @(posedge mclk);
        #1;
        if (wr_take === 1'h1) begin
          k++;
          wr_data = wq[k];
        end
        if (rd_valid === 1'h1) begin
          rq[nrd] = rd_data;
          nrd++;
        end
      end
    end
  endtask

  // reset in the middle of a read must drop cs, sclk, scl and sda_oe to their idle levels within two clocks
  task t_reset_mid;
    begin
      use_i2c = 1'h0;
      rnw = 1'h1;
      reg_addr = 10'h000;
      word_cnt = 8'h08;
      start_req = 1'h1;
      @(posedge mclk);
      #1 start_req = 1'h0;
      repeat (100) @(posedge mclk);
      #1 reset_n = 1'h0;
      repeat (2) @(posedge mclk);
      #1;
      chk({8'h00, busy, spi_cs_n, spi_sclk, rd_valid, i2c_scl, sda_oe, nack_err, wr_take},
        16'h0048);
      chk(rd_data, 16'h0000);
      reset_n = 1'h1;
    end
  endtask

  task t_spi_wr;
    begin
      wq[0] = 16'h1a2b;
      wq[1] = 16'h3c4d;
      run(1'h0, 1'h0, 10'h010, 8'h02);
      chk(dev.mem[10'h010], 16'h1a2b);
      chk(dev.mem[10'h011], 16'h3c4d);
    end
  endtask

  task t_spi_top;
    begin
      dev.mem[0] = 16'h5555;
      wq[0] = 16'h7e81;
      wq[1] = 16'h0ff0;
      run(1'h0, 1'h0, TOP, 8'h02);
      chk(dev.mem[TOP], 16'h7e81);
      chk(dev.mem[0], 16'h5555);
    end
  endtask

  task t_spi_rd;
    begin
      dev.mem[TOP - 10'h001] = 16'h2468;
      run(1'h0, 1'h1, TOP - 10'h001, 8'h03);
      chk(nrd[15:0], 16'h0003);
      chk(rq[0], 16'h2468);
      chk(rq[1], 16'h7e81);
      chk(rq[2], 16'h7e81);
    end
  endtask

  task t_i2c_wr;
    logic [9:0] a;
    begin
      for (int s = 0; s < 4; s++) begin
        strap = s[1:0];
        dev_strap = s[1:0];
        a = 10'h2f0 + {7'h00, s[1:0], 1'h0};
        wq[0] = {8'h81, 6'h00, s[1:0]};
        wq[1] = {8'h3e, 6'h00, s[1:0]};
        run(1'h1, 1'h0, a, 8'h02);
        chk(dev.mem[a], wq[0]);
        chk(dev.mem[a + 10'h001], wq[1]);
      end
    end
  endtask

  task t_i2c_top;
    begin
      wq[0] = 16'hc3a5;
      wq[1] = 16'h1111;
      run(1'h1, 1'h0, TOP, 8'h02);
      chk(dev.mem[TOP], 16'hc3a5);
      chk(dev.mem[0], 16'h5555);
    end
  endtask

  task t_i2c_rd;
    begin
      dev.mem[TOP - 10'h001] = 16'h4b2d;
      run(1'h1, 1'h1, TOP - 10'h001, 8'h03);
      chk(nrd[15:0], 16'h0003);
      chk(rq[0], 16'h4b2d);
      chk(rq[1], 16'hc3a5);
      chk(rq[2], 16'hc3a5);
      chk({15'h0000, nack_err}, 16'h0000);
    end
  endtask

  task t_i2c_nack;
    begin
      strap = 2'h3;
      dev_strap = 2'h0;
      run(1'h1, 1'h0, 10'h005, 8'h01);
      chk({15'h0000, nack_err}, 16'h0001);
      chk(dev.mem[10'h005], 16'h0000);
    end
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    #1 reset_n = 1'h1;
    t_reset_mid();
    t_spi_wr();
    t_spi_top();
    t_spi_rd();
    t_i2c_wr();
    t_i2c_top();
    t_i2c_rd();
    t_i2c_nack();
    report_and_stop();
  end
endmodule
